// ==== adccal_pkg.sv ====
// adccal_pkg: constants and types for the command decoder and calibration engine
package adccal_pkg;
	localparam logic [6:0] OP_WAKE = 7'h00;
	localparam logic [6:0] OP_STANDBY = 7'h01;
	localparam logic [6:0] OP_SYNC = 7'h02;
	localparam logic [6:0] OP_RESET = 7'h03;
	localparam logic [7:0] OP_CONT_READ = 8'h10;
	localparam logic [7:0] OP_STOP_READ = 8'h11;
	localparam logic [7:0] OP_READ_DATA = 8'h12;
	localparam logic [7:0] OP_OFFSET_CAL = 8'h60;
	localparam logic [7:0] OP_GAIN_CAL = 8'h61;
	localparam logic [2:0] OP_REG_READ = 3'h1;
	localparam logic [2:0] OP_REG_WRITE = 3'h2;
	localparam logic [2:0] OP_REG_COUNT = 3'h0;
	localparam logic [4:0] ADDR_OFC_LOW = 5'h05;
	localparam logic [4:0] ADDR_OFC_MID = 5'h06;
	localparam logic [4:0] ADDR_OFC_HIGH = 5'h07;
	localparam logic [4:0] ADDR_FSC_LOW = 5'h08;
	localparam logic [4:0] ADDR_FSC_MID = 5'h09;
	localparam logic [4:0] ADDR_FSC_HIGH = 5'h0A;
	localparam logic [23:0] OFC_RESET = 24'h000000;
	localparam logic [23:0] FSC_RESET = 24'h400000;
	localparam int GAIN_FRAC_BITS = 22;
	localparam logic [31:0] FULL_SCALE_CODE = 32'h7FFFFFFF;
	localparam logic [6:0] SETTLE_PERIODS = 7'h40;
	localparam logic [4:0] CAL_READINGS = 5'h10;
	localparam logic [6:0] TIMEOUT_PERIODS = 7'h40;
	localparam int CMD_GAP_CYCLES = 24;
	localparam logic [2:0] DATA_READY_N_PULSE = 3'h4;
	localparam logic [5:0] DIV_STEPS = 6'h36;
	typedef struct packed
	{
		logic [23:0] gain;
		logic [23:0] offset;
	} adccal_corr_t;
	typedef enum logic [1:0]
	{
		ST_OPCODE = 2'b00,
		ST_COUNT = 2'b01,
		ST_WRITE = 2'b10,
		ST_READ = 2'b11
	} adccal_cmd_st_t;
	typedef enum logic [1:0]
	{
		CAL_IDLE = 2'b00,
		CAL_GATHER = 2'b01,
		CAL_DIVIDE = 2'b10
	} adccal_cal_st_t;
endpackage : adccal_pkg

// ==== adccal_core.sv ====
// adccal_core: serial command decoder, register access, scaling and calibration engine
// Functional notes
// [R1] result = (filter output - offset word) * gain word / 400000h
// [R2] 24-bit offset word is aligned to bits 31..8 of the 32-bit data
// [R3] offset word is twos complement, default zero means no correction
// [R4] gain word unsigned, 400000h is unity, default 400000h
// [R5] each word sits in three byte registers, low, mid, high addresses
// [R6] sinc-only configuration passes filter output through unscaled
// [R7] words are written by host register writes and by calibration
// [R8] host calibrates with stop, sync, continuous, then stop, cal, continuous
// [R9] data-ready falls 64 data periods after a synchronize
// [R10] calibration finishes within 16 data periods
// [R11] offset calibration averages 16 raw readings into the offset word
// [R12] gain calibration averages 16 readings and stores the compensating gain
// [R13] host should run gain calibration after offset calibration
// [R14] host leaves 24 device clocks between commands and bytes
// [R15] stop-continuous-read disables direct conversion output
// [R16] exit-standby 0000000X, enter-standby 0000001X
// [R17] synchronize 0000010X, register reset 0000011X
// [R18] continuous-read 10h, stop 11h, read-by-command 12h
// [R19] register read 001+addr, write 010+addr, then 000+count-1
// [R20] offset calibration 60h, gain calibration 61h
// [R21] only register commands have a second byte and data bytes
// [R22] exit-standby outside standby has no effect
// [R23] serial input sampled on rising, output changed on falling clock
// [R24] serial clock low 64 data periods aborts the transfer
// [R25] continuous-read mode is active after reset
// [R26] after stop-continuous-read data-ready is held high
// [R27] standby keeps registers and serial port, left only by exit-standby
// [R28] scaled result saturates at the 32-bit twos complement limits
// [R29] unknown opcodes are ignored
`timescale 1ns/100ps
module adccal_core
	import adccal_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic sclk,
	input wire logic din,
	input wire logic [31:0] filt_data,
	input wire logic filt_valid,
	input wire logic sinc_only,
	output logic dout,
	output logic data_ready_n,
	output logic [31:0] result,
	output logic result_valid,
	output logic standby,
	output logic conv_restart,
	output adccal_pkg::adccal_corr_t corr
);
	import adccal_pkg::*;

	logic [2:0] sclk_q;
	logic [1:0] din_q;
	logic sclk_rise;
	logic sclk_fall;
	logic [2:0] bit_cnt_q;
	logic [6:0] shreg_q;
	logic [7:0] rx_byte;
	logic byte_done;
	logic [6:0] low_cnt_q;
	logic serial_abort;
	adccal_cmd_st_t st_q;
	logic [4:0] addr_q;
	logic [4:0] left_q;
	logic is_write_q;
	logic op_byte;
	logic cmd_wake, cmd_standby, cmd_sync, cmd_reset;
	logic cmd_cont, cmd_stop, cmd_rdata, cmd_offset_cal_command, cmd_gain_cal_command;
	logic wr_en;
	logic load_reg;
	logic [4:0] rd_addr;
	logic [7:0] rd_byte;
	logic cont_mode_q;
	logic standby_q;
	logic pend_q;
	logic restart_q;
	logic [6:0] settle_q;
	adccal_corr_t corr_q;
	logic signed [32:0] diff;
	logic signed [57:0] prod;
	logic [35:0] scaled;
	logic sat_pos;
	logic sat_neg;
	logic [31:0] result_q;
	logic result_valid_q;
	adccal_cal_st_t cal_st_q;
	logic cal_gain_q;
	logic [4:0] cal_cnt_q;
	logic [36:0] acc_q;
	logic [36:0] acc_next;
	logic [32:0] sample;
	logic [32:0] avg;
	logic off_store;
	logic gain_store;
	logic [5:0] div_cnt_q;
	logic [53:0] num_q;
	logic [33:0] rem_q;
	logic [32:0] den_q;
	logic [33:0] shifted;
	logic [23:0] gain_val;
	logic ready_evt;
	logic [2:0] hold_q;
	logic data_ready_n_q;
	logic conv_load;
	logic [31:0] tx_q;
	logic dout_q;

	// pins cross into clk; only stage 1 and 2 are read by logic
	always_ff @(posedge clk)
	begin
		sclk_q <= {sclk_q[1:0], sclk};
		din_q <= {din_q[0], din};
	end

	assign sclk_rise = sclk_q[1] & ~sclk_q[2];
	assign sclk_fall = ~sclk_q[1] & sclk_q[2];
	assign rx_byte = {shreg_q, din_q[1]};
	assign byte_done = sclk_rise && (bit_cnt_q == 3'h7);

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			low_cnt_q <= 7'h00;
		else if (sclk_q[1])
			low_cnt_q <= 7'h00;
		else if (filt_valid && (low_cnt_q != TIMEOUT_PERIODS))
			low_cnt_q <= low_cnt_q + 7'h01;
	end

	// idle sclk is low in continuous mode, so this fires harmlessly there too
	assign serial_abort = filt_valid && !sclk_q[1] && (low_cnt_q == TIMEOUT_PERIODS - 7'h01); // R24

	always_ff @(posedge clk)
	begin
		if (!reset_n || serial_abort) // R24
		begin
			bit_cnt_q <= 3'h0;
			shreg_q <= 7'h00;
		end
		else if (sclk_rise) // R23
		begin
			bit_cnt_q <= bit_cnt_q + 3'h1;
			shreg_q <= rx_byte[6:0];
		end
	end

	assign op_byte = byte_done && (st_q == ST_OPCODE);
	assign cmd_wake = op_byte && (rx_byte[7:1] == OP_WAKE); // R16
	assign cmd_standby = op_byte && (rx_byte[7:1] == OP_STANDBY); // R16
	assign cmd_sync = op_byte && (rx_byte[7:1] == OP_SYNC); // R17
	assign cmd_reset = op_byte && (rx_byte[7:1] == OP_RESET); // R17
	assign cmd_cont = op_byte && (rx_byte == OP_CONT_READ); // R18
	assign cmd_stop = op_byte && (rx_byte == OP_STOP_READ); // R18
	assign cmd_rdata = op_byte && (rx_byte == OP_READ_DATA); // R18
	assign cmd_offset_cal_command = op_byte && (rx_byte == OP_OFFSET_CAL); // R20
	assign cmd_gain_cal_command = op_byte && (rx_byte == OP_GAIN_CAL); // R20
	assign wr_en = byte_done && (st_q == ST_WRITE);
	assign load_reg = byte_done && ((st_q == ST_COUNT && !is_write_q
		&& rx_byte[7:5] == OP_REG_COUNT) || (st_q == ST_READ && left_q != 5'h00));
	assign rd_addr = (st_q == ST_COUNT) ? addr_q : addr_q + 5'h01;

	always_comb
	begin
		case (rd_addr)
			ADDR_OFC_LOW: rd_byte = corr_q.offset[7:0];
			ADDR_OFC_MID: rd_byte = corr_q.offset[15:8];
			ADDR_OFC_HIGH: rd_byte = corr_q.offset[23:16];
			ADDR_FSC_LOW: rd_byte = corr_q.gain[7:0];
			ADDR_FSC_MID: rd_byte = corr_q.gain[15:8];
			ADDR_FSC_HIGH: rd_byte = corr_q.gain[23:16];
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n || serial_abort) // R24
		begin
			st_q <= ST_OPCODE;
			addr_q <= 5'h00;
			left_q <= 5'h00;
			is_write_q <= 1'b0;
		end
		else if (byte_done)
		begin
			case (st_q)
				ST_OPCODE:
				begin
					// single-byte opcodes stay here; unknown ones fall through
					if (rx_byte[7:5] == OP_REG_READ || rx_byte[7:5] == OP_REG_WRITE) // R19 R21
					begin
						st_q <= ST_COUNT;
						addr_q <= rx_byte[4:0];
						is_write_q <= (rx_byte[7:5] == OP_REG_WRITE);
					end
				end
				ST_COUNT:
				begin
					left_q <= rx_byte[4:0]; // R19
					if (rx_byte[7:5] != OP_REG_COUNT)
						st_q <= ST_OPCODE; // R29
					else if (is_write_q)
						st_q <= ST_WRITE;
					else
						st_q <= ST_READ;
				end
				ST_WRITE, ST_READ:
				begin
					left_q <= left_q - 5'h01;
					addr_q <= addr_q + 5'h01;
					if (left_q == 5'h00)
						st_q <= ST_OPCODE;
				end
				default: st_q <= ST_OPCODE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			cont_mode_q <= 1'b1; // R25
			standby_q <= 1'b0;
			pend_q <= 1'b0;
			restart_q <= 1'b0;
		end
		else
		begin
			if (cmd_reset || cmd_cont)
				cont_mode_q <= 1'b1; // R25
			else if (cmd_stop)
				cont_mode_q <= 1'b0; // R15
			if (cmd_standby)
				standby_q <= 1'b1; // R27
			else if (cmd_wake)
				standby_q <= 1'b0; // R22
			if (cmd_rdata)
				pend_q <= 1'b1;
			else if (conv_load || cmd_reset)
				pend_q <= 1'b0;
			restart_q <= cmd_sync || cmd_reset;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n || cmd_reset)
			settle_q <= 7'h00;
		else if (cmd_sync)
			settle_q <= SETTLE_PERIODS; // R9
		else if (filt_valid && settle_q != 7'h00)
			settle_q <= settle_q - 7'h01; // R9
	end

	// scaling datapath
	assign diff = $signed({filt_data[31], filt_data}) - $signed({corr_q.offset[23], corr_q.offset, 8'h00}); // R1 R2 R3
	assign prod = diff * $signed({1'b0, corr_q.gain}); // R1 R4
	assign scaled = prod[57:GAIN_FRAC_BITS];
	assign sat_pos = !scaled[35] && (scaled[34:31] != 4'h0); // R28
	assign sat_neg = scaled[35] && (scaled[34:31] != 4'hF); // R28

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			result_q <= 32'h00000000;
			result_valid_q <= 1'b0;
		end
		else
		begin
			result_valid_q <= filt_valid;
			if (filt_valid)
			begin
				if (sinc_only)
					result_q <= filt_data; // R6
				else if (sat_pos)
					result_q <= 32'h7FFFFFFF; // R28
				else if (sat_neg)
					result_q <= 32'h80000000; // R28
				else
					result_q <= scaled[31:0]; // R1
			end
		end
	end

	// calibration engine
	assign sample = cal_gain_q ? diff : {filt_data[31], filt_data}; // R11
	assign acc_next = acc_q + {{4{sample[32]}}, sample};
	assign avg = acc_next[36:4];
	assign off_store = (cal_st_q == CAL_GATHER) && filt_valid && !cal_gain_q
		&& (cal_cnt_q == CAL_READINGS - 5'h01);
	assign gain_store = (cal_st_q == CAL_DIVIDE) && (div_cnt_q == DIV_STEPS);
	assign shifted = {rem_q[32:0], num_q[53]};
	assign gain_val = (num_q[53:24] != 30'h0) ? 24'hFFFFFF : num_q[23:0];

	always_ff @(posedge clk)
	begin
		if (!reset_n || cmd_reset)
		begin
			cal_st_q <= CAL_IDLE;
			cal_gain_q <= 1'b0;
			cal_cnt_q <= 5'h00;
			acc_q <= 37'h0;
			div_cnt_q <= 6'h00;
			num_q <= 54'h0;
			rem_q <= 34'h0;
			den_q <= 33'h0;
		end
		else
		begin
			case (cal_st_q)
				CAL_IDLE:
				begin
					if (cmd_offset_cal_command || cmd_gain_cal_command) // R10
					begin
						cal_st_q <= CAL_GATHER;
						cal_gain_q <= cmd_gain_cal_command;
						cal_cnt_q <= 5'h00;
						acc_q <= 37'h0;
					end
				end
				CAL_GATHER:
				begin
					if (filt_valid)
					begin
						acc_q <= acc_next;
						cal_cnt_q <= cal_cnt_q + 5'h01;
						if (cal_cnt_q == CAL_READINGS - 5'h01) // R11 R12
						begin
							cal_st_q <= cal_gain_q ? CAL_DIVIDE : CAL_IDLE;
							// full scale over the absolute mean reading, in units of 2^-22
							den_q <= avg[32] ? 33'(-avg) : avg; // R12
							num_q <= {FULL_SCALE_CODE, 22'h0};
							rem_q <= 34'h0;
							div_cnt_q <= 6'h00;
						end
					end
				end
				CAL_DIVIDE:
				begin
					// one quotient bit per clock keeps the divider small
					if (div_cnt_q == DIV_STEPS)
						cal_st_q <= CAL_IDLE;
					else
					begin
						div_cnt_q <= div_cnt_q + 6'h01;
						if (shifted >= {1'b0, den_q})
						begin
							rem_q <= shifted - {1'b0, den_q};
							num_q <= {num_q[52:0], 1'b1};
						end
						else
						begin
							rem_q <= shifted;
							num_q <= {num_q[52:0], 1'b0};
						end
					end
				end
				default: cal_st_q <= CAL_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n || cmd_reset)
		begin
			corr_q.offset <= OFC_RESET; // R3
			corr_q.gain <= FSC_RESET; // R4
		end
		else
		begin
			if (off_store)
				corr_q.offset <= acc_next[35:12]; // R7 R11
			if (gain_store)
				corr_q.gain <= gain_val; // R7 R12
			if (wr_en) // R7
			begin
				case (addr_q) // R5
					ADDR_OFC_LOW: corr_q.offset[7:0] <= rx_byte;
					ADDR_OFC_MID: corr_q.offset[15:8] <= rx_byte;
					ADDR_OFC_HIGH: corr_q.offset[23:16] <= rx_byte;
					ADDR_FSC_LOW: corr_q.gain[7:0] <= rx_byte;
					ADDR_FSC_MID: corr_q.gain[15:8] <= rx_byte;
					ADDR_FSC_HIGH: corr_q.gain[23:16] <= rx_byte;
					default: ;
				endcase
			end
		end
	end

	// data-ready and serial output
	assign ready_evt = result_valid_q && (cont_mode_q || pend_q) && (settle_q == 7'h00)
		&& (cal_st_q == CAL_IDLE) && !standby_q; // R9 R26
	assign conv_load = (hold_q == 3'h1) && (cont_mode_q || pend_q); // R15

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			hold_q <= 3'h0;
			data_ready_n_q <= 1'b1;
		end
		else if (ready_evt)
		begin
			hold_q <= DATA_READY_N_PULSE;
			data_ready_n_q <= 1'b1;
		end
		else
		begin
			if (hold_q != 3'h0)
				hold_q <= hold_q - 3'h1;
			if (!cont_mode_q && !pend_q)
				data_ready_n_q <= 1'b1; // R26
			else if (sclk_fall)
				data_ready_n_q <= 1'b1;
			else if (conv_load)
				data_ready_n_q <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			tx_q <= 32'h00000000;
			dout_q <= 1'b0;
		end
		else if (load_reg)
			tx_q <= {rd_byte, 24'h000000};
		else if (conv_load) // R15
		begin
			tx_q <= {result_q[30:0], 1'b0};
			dout_q <= result_q[31];
		end
		else if (sclk_fall) // R23
		begin
			dout_q <= tx_q[31];
			tx_q <= {tx_q[30:0], 1'b0};
		end
	end

	assign dout = dout_q;
	assign data_ready_n = data_ready_n_q;
	assign result = result_q;
	assign result_valid = result_valid_q;
	assign standby = standby_q;
	assign conv_restart = restart_q;
	assign corr = corr_q;

	sequence s_data_ready_n_high;
		data_ready_n [*4];
	endsequence

	a_data_ready_n_pulse_high: assert property (@(posedge clk) disable iff (!reset_n) // R26
		ready_evt |=> s_data_ready_n_high)
		else $error("data ready not held high after new result");
	a_stop_suppress: assert property (@(posedge clk) disable iff (!reset_n) // R26
		(!cont_mode_q && !pend_q) [*2] |-> data_ready_n)
		else $error("data ready low while continuous read stopped");
	a_stop_mode: assert property (@(posedge clk) disable iff (!reset_n) // R15
		cmd_stop && !cmd_reset |=> !cont_mode_q ##1 !conv_load || pend_q)
		else $error("stop command did not leave continuous read");
	a_reset_cont: assert property (@(posedge clk) disable iff (!reset_n) // R25
		cmd_reset |=> cont_mode_q && corr_q.gain == 24'h400000 && corr_q.offset == 24'h0)
		else $error("reset command did not restore defaults");
	a_wake_noop: assert property (@(posedge clk) disable iff (!reset_n) // R22
		cmd_wake && !standby_q |=> !standby_q && $stable(cont_mode_q))
		else $error("exit standby changed state outside standby");
	a_standby_hold: assert property (@(posedge clk) disable iff (!reset_n) // R27
		(op_byte && rx_byte[7:1] == 7'h01) ##1 !cmd_wake |=> standby_q)
		else $error("standby not held");
	a_sinc_bypass: assert property (@(posedge clk) disable iff (!reset_n) // R6
		filt_valid && sinc_only |=> result_q == $past(filt_data) && result_valid_q)
		else $error("sinc only result was scaled");
	a_unity_scale: assert property (@(posedge clk) disable iff (!reset_n) // R1
		filt_valid && !sinc_only && corr_q.offset == 24'h0 && corr_q.gain == 24'h400000
		|=> result_q == $past(filt_data))
		else $error("unity correction changed the result");
	a_sat_limit: assert property (@(posedge clk) disable iff (!reset_n) // R28
		filt_valid && !sinc_only && sat_pos |=> result_q == 32'h7FFFFFFF)
		else $error("positive overflow not saturated");
	a_offset_store: assert property (@(posedge clk) disable iff (!reset_n) // R11
		off_store && !wr_en && !cmd_reset
		|=> corr_q.offset == $past(acc_next[35:12]) && cal_st_q == CAL_IDLE)
		else $error("offset calibration result not stored");
	a_divide_bound: assert property (@(posedge clk) disable iff (!reset_n) // R12
		$rose(cal_st_q == CAL_DIVIDE) |-> ##[54:56] cal_st_q == CAL_IDLE)
		else $error("gain divide did not finish in time");
	a_timeout_abort: assert property (@(posedge clk) disable iff (!reset_n) // R24
		serial_abort |=> bit_cnt_q == 3'h0 && st_q == ST_OPCODE)
		else $error("serial timeout did not reset the port");
	a_reg_write: assert property (@(posedge clk) disable iff (!reset_n) // R5
		wr_en && addr_q == 5'h06 && !off_store && !cmd_reset |=> corr_q.offset[15:8] == $past(rx_byte))
		else $error("middle offset byte not written");
endmodule : adccal_core

// ==== adccal_host.sv ====
// adccal_host: serial host model driving command and data transfers
`timescale 1ns/100ps
module adccal_host
(
	input wire logic clk,
	output logic sclk,
	output logic din,
	input wire logic dout
);
	initial
	begin
		sclk = 1'h0;
		din = 1'h0;
	end
	// msb first, 48 ns per bit; din moves with the sclk fall, sclk rests low between frames
	task automatic xfer(input int n, input logic [31:0] v, output logic [31:0] r);
		r = '0;
		for (int i = n - 1; i >= 0; i--)
		begin
			din = v[i];
			repeat (6) @(negedge clk);
			sclk = 1'h1;
			r[i] = dout;
			repeat (6) @(negedge clk);
			sclk = 1'h0;
		end
		// idle data line must not look like the last bit
		din = ~din;
		repeat (30) @(negedge clk);
	endtask : xfer
endmodule : adccal_host

// ==== adccal_tb.sv ====
// tb: self-checking bench for the command decoder and calibration engine
`timescale 1ns/100ps
module tb;
	import adccal_pkg::*;
	logic clk, reset_n, sclk, din, dout, filt_valid, sinc_only;
	logic data_ready_n, result_valid, standby, conv_restart, stb;
	logic [31:0] filt_data, result, rd, e, v;
	adccal_corr_t corr;
	int n_fail = 0;
	int check_count = 0;
	int cyc = 0;
	int n_rst = 0;
	int n0;
	logic [23:0] m_off, m_gain;
	logic [55:0] img;
	longint q;
	logic [7:0] ops [9] = '{8'h02, 8'h00, 8'h00, 8'h03, 8'h01, 8'h04, 8'h05, 8'h06, 8'h07};
	logic [7:0] bad [7] = '{8'h45, 8'hE0, 8'h08, 8'h13, 8'h5F, 8'h62, 8'hFF};
	adccal_core u_dut (.clk(clk), .reset_n(reset_n), .sclk(sclk), .din(din),
		.filt_data(filt_data), .filt_valid(filt_valid), .sinc_only(sinc_only), .dout(dout),
		.data_ready_n(data_ready_n), .result(result), .result_valid(result_valid),
		.standby(standby), .conv_restart(conv_restart), .corr(corr));
	adccal_host u_host (.clk(clk), .sclk(sclk), .din(din), .dout(dout));
	initial
	begin
		clk = 1'h0;
		forever
			#2 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (conv_restart === 1'h1)
			n_rst <= n_rst + 1;
		if (cyc == 60000)
		begin
			n_fail = n_fail + 1;
			results();
		end
	end
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results
	task automatic check(input string what, input logic [47:0] x, input logic [47:0] got);
		check_count++;
		if (got !== x)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, x, got);
		end
	endtask : check
	function automatic logic [31:0] scale(input logic [31:0] f, input logic s);
		longint p;
		p = longint'($signed(f)) - (longint'($signed(m_off)) <<< 8);
		p = (p * longint'(m_gain)) >>> 22;
		if (s)
			return f;
		if (p > 64'sh7FFFFFFF)
			return 32'h7FFFFFFF;
		if (p < -64'sh80000000)
			return 32'h80000000;
		return p[31:0];
	endfunction : scale
	task automatic cmd(input logic [7:0] b);
		u_host.xfer(8, {24'h0, b}, rd);
	endtask : cmd
	// one data period: new filter word, result compare, data-ready timing
	task automatic sample(input logic [31:0] f, input logic s, input bit chk, input logic rdy);
		e = scale(f, s);
		@(negedge clk);
		filt_data = f;
		sinc_only = s;
		filt_valid = 1'h1;
		@(negedge clk);
		filt_valid = 1'h0;
		for (int i = 0; i < 3 && result_valid !== 1'h1; i++)
			@(negedge clk);
		if (chk)
		begin
			check("result", {1'h1, e}, {result_valid, result});
			repeat (2) @(negedge clk);
			check("rdy busy", 1'h1, data_ready_n);
			repeat (3) @(negedge clk);
			check("rdy", 1'(~rdy), data_ready_n);
		end
		else
			repeat (6) @(negedge clk);
	endtask : sample
	task automatic rregs(input logic [4:0] a, input int n);
		img = {8'h00, m_gain, m_off};
		cmd({OP_REG_READ, a});
		cmd({OP_REG_COUNT, 5'(n - 1)});
		for (int i = 0; i < n; i++)
		begin
			u_host.xfer(8, 32'h0, rd);
			check("reg", img[8 * (a - 5 + i) +: 8], rd);
		end
	endtask : rregs
	task automatic wregs();
		img = {8'h00, m_gain, m_off};
		cmd({OP_REG_WRITE, ADDR_OFC_LOW});
		cmd({OP_REG_COUNT, 5'h05});
		for (int i = 0; i < 6; i++)
			u_host.xfer(8, {24'h0, img[8 * i +: 8]}, rd);
	endtask : wregs
	initial
	begin
		void'($urandom(62018));
		reset_n = 1'h0;
		filt_data = 32'h0;
		filt_valid = 1'h0;
		sinc_only = 1'h0;
		m_off = OFC_RESET;
		m_gain = FSC_RESET;
		repeat (5) @(negedge clk);
		reset_n = 1'h1;
		@(negedge clk);
		check("corr", {FSC_RESET, OFC_RESET}, corr);
		sample($urandom, 1'h0, 1'h1, 1'h1);
		cmd(OP_STOP_READ);
		rregs(ADDR_OFC_LOW, 7);
		$display("test reset done");
		for (int r = 0; r < 2; r++)
		begin
			m_off = r ? 24'($urandom_range(0, 511)) - 24'h100 : 24'($urandom);
			m_gain = r ? 24'h380000 + 24'($urandom_range(0, 24'h0FFFFF)) : 24'($urandom);
			wregs();
			check("corr", {m_gain, m_off}, corr);
			cmd(OP_CONT_READ);
			repeat (3)
			begin
				sample($urandom, 1'($urandom), 1'h1, 1'h1);
				u_host.xfer(32, 32'h0, rd);
				check("dout", e, rd);
			end
			cmd(OP_STOP_READ);
			sample($urandom, 1'h0, 1'h1, 1'h0);
			cmd(OP_READ_DATA);
			sample($urandom, 1'h0, 1'h1, 1'h1);
			u_host.xfer(32, 32'h0, rd);
			check("dout", e, rd);
		end
		$display("test scaling done");
		foreach (bad[i])
			cmd(bad[i]);
		check("corr", {m_gain, m_off}, corr);
		sample($urandom, 1'h0, 1'h1, 1'h0);
		check("stby", 1'h0, standby);
		stb = 1'h0;
		foreach (ops[i])
		begin
			n0 = n_rst;
			cmd(ops[i]);
			if (ops[i][7:1] == OP_STANDBY)
				stb = 1'h1;
			if (ops[i][7:1] == OP_WAKE)
				stb = 1'h0;
			if (ops[i][7:1] == OP_RESET)
			begin
				m_off = OFC_RESET;
				m_gain = FSC_RESET;
			end
			check("stby", stb, standby);
			check("restart", ops[i][2], 48'(n_rst - n0));
			check("corr", {m_gain, m_off}, corr);
		end
		cmd({OP_SYNC, 1'h1});
		repeat (63)
			sample($urandom, 1'h0, 1'h1, 1'h0);
		sample($urandom, 1'h0, 1'h1, 1'h1);
		$display("test control done");
		// host order: stop, calibrate, continuous; gain only after offset
		cmd(OP_STOP_READ);
		cmd(OP_OFFSET_CAL);
		cmd(OP_CONT_READ);
		v = 32'($signed($urandom) >>> 4);
		q = $urandom_range(0, 4095);
		for (int i = 0; i < 16; i++)
			sample(32'(v + (i[0] ? q : -q)), 1'h0, 1'h0, 1'h0);
		repeat (4) @(negedge clk);
		m_off = v[31:8];
		check("ofs cal", {m_gain, m_off}, corr);
		cmd(OP_STOP_READ);
		rregs(ADDR_OFC_LOW, 3);
		cmd(OP_GAIN_CAL);
		cmd(OP_CONT_READ);
		v = 32'h30000000 + $urandom_range(0, 32'h0FFFFFFF);
		for (int i = 0; i < 16; i++)
			sample(v, 1'h0, 1'h0, 1'h0);
		repeat (60) @(negedge clk);
		q = longint'($signed(v)) - (longint'($signed(m_off)) <<< 8);
		q = (64'sh7FFFFFFF <<< 22) / (q < 0 ? -q : q);
		m_gain = q > 64'shFFFFFF ? 24'hFFFFFF : q[23:0];
		check("gain cal", {m_gain, m_off}, corr);
		sample($urandom, 1'h0, 1'h1, 1'h1);
		$display("test calibration done");
		u_host.xfer(4, 32'h0, rd);
		repeat (64)
			sample($urandom, 1'h0, 1'h0, 1'h0);
		cmd({OP_STANDBY, 1'h0});
		check("stby", 1'h1, standby);
		cmd(OP_STOP_READ);
		rregs(ADDR_OFC_LOW, 6);
		cmd({OP_WAKE, 1'h1});
		check("stby", 1'h0, standby);
		$display("test timeout done");
		results();
	end
endmodule : tb
